// ===== logic/mscs_phy_regs.sv
// Local design decision: the management link register port.
`timescale 1ns/10ps
// Summary of operation
// R1 - idle inserted sets latched-high status flag
// R2 - idle deleted sets latched-high status flag
// R3 - line loopback bit loops media, resets zero
// R4 - link down: speed code 00=10, else 1000
// R5 - speed field resets to 1000 code
// R6 - speed field also used in mac loopback
// R7 - software sets speed and forced speed alike
// R8 - speed and timing bits apply at soft reset
// R9 - receive timing bit centres clock, resets one
// R10 - transmit timing bit delays clock, resets one
// R11 - carrier extension block bit, resets zero, retained
// R12 - software matches supply level bit to supply
// R13 - supply level initial value from straps
// R14 - read-only bit reports 1.8v supply
// R15 - software writes back read reserved values
// R16 - software writes only reset values to reserved
// R17 - latched flags clear on read unless event
module mscs_phy_regs
  import mscs_pkg::*;
#(
  parameter logic [3:0] IMP_RSV_11_8_RST = 4'h0,
  parameter logic [3:0] IMP_RSV_3_0_RST = 4'h0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // management link
  mscs_if.dev lnk,
  // device events and state
  input wire logic idle_ins_evt,
  input wire logic idle_del_evt,
  input wire logic soft_reset,
  input wire logic link_up,
  input wire logic link_speed_1000,
  input wire logic mac_loopback_on,
  // pins
  input wire logic [1:0] strap_cfg,
  input wire logic io_18v_pin,
  // controls
  output logic line_loopback,
  output logic mac_clk_1000,
  output logic rx_clk_centred,
  output logic tx_clk_delayed,
  output logic block_carrier_ext,
  output logic io_supply_level,
  output logic impedance_cal_go
);
  logic clk_s, clk_d, dat_s, io18_s;
  logic [1:0] strap_s;
  logic in_frame, op_read, rd_act;
  logic [4:0] bit_cnt, addr_q;
  logic [21:0] rx_sh;
  logic [15:0] rd_sh;
  logic ins_flag, del_flag;
  logic spd_lsb, spd_msb, rx_tim, tx_tim;
  logic [2:0] rsv2_0;
  logic [1:0] spd_app;
  logic rx_app, tx_app;
  logic [3:0] rsv11_8, rsv3_0;
  logic [1:0] rsv7_6, strap_wait;

  mscs_sync #(.W(1)) u_sclk (.clk(pclk), .rst_n(presetn), .d(lnk.mgmt_clk), .q(clk_s));
  mscs_sync #(.W(1)) u_sdat (.clk(pclk), .rst_n(presetn), .d(lnk.mgmt_out), .q(dat_s));
  mscs_sync #(.W(1)) u_s18 (.clk(pclk), .rst_n(presetn), .d(io_18v_pin), .q(io18_s));
  mscs_sync #(.W(2)) u_sstrap (.clk(pclk), .rst_n(presetn), .d(strap_cfg), .q(strap_s));

  wire rise = clk_s & ~clk_d;
  wire fall = ~clk_s & clk_d;
  wire addr_done = rise & in_frame & (bit_cnt == FRAME_ADDR_LAST);
  wire frame_end = rise & in_frame & (bit_cnt == FRAME_LAST);
  wire [4:0] addr_now = {rx_sh[3:0], dat_s};
  wire read_start = addr_done & rx_sh[4];
  wire wr_done = frame_end & ~op_read;
  wire [15:0] wdata = {rx_sh[14:0], dat_s};
  wire wr_ctl2 = wr_done & (addr_q == REG_MAC_IF_CONTROL_TWO);
  wire wr_imp = wr_done & (addr_q == REG_OUTPUT_IMPEDANCE_OVERRIDE);
  wire rd_stat = read_start & (addr_now == REG_MAC_FIFO_STATUS);

  wire [15:0] stat_word = {12'h000, ins_flag, del_flag, 2'h0};
  wire [15:0] ctl2_word = {1'b0, line_loopback, spd_lsb, CTL2_RSV_12_7, spd_msb, rx_tim, tx_tim,
                           block_carrier_ext, rsv2_0};
  wire [15:0] imp_word = {impedance_cal_go, 1'b0, io_supply_level, io18_s, rsv11_8, rsv7_6, 2'h0, rsv3_0}; // R14
  wire [15:0] rd_word = (addr_now == REG_MAC_FIFO_STATUS) ? stat_word :
                        (addr_now == REG_MAC_IF_CONTROL_TWO) ? ctl2_word :
                        (addr_now == REG_OUTPUT_IMPEDANCE_OVERRIDE) ? imp_word : 16'h0000;
  wire speed_override = ~link_up | mac_loopback_on;

  // frame receiver; data is sampled on the link clock rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_d <= 1'b0;
      in_frame <= 1'b0;
      bit_cnt <= 5'h00;
      rx_sh <= '0;
      op_read <= 1'b0;
      addr_q <= 5'h00;
    end else begin
      clk_d <= clk_s;
      if (rise) begin
        if (!in_frame) begin
          in_frame <= ~dat_s;
          bit_cnt <= 5'h01;
        end else begin
          rx_sh <= {rx_sh[20:0], dat_s};
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == FRAME_LAST)
            in_frame <= 1'b0;
        end
      end
      if (addr_done) begin
        addr_q <= addr_now;
        op_read <= rx_sh[4];
      end
    end
  end

  // read data leaves on falling edges so the controller samples it stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_act <= 1'b0;
      rd_sh <= 16'h0000;
      lnk.mgmt_in <= 1'b1;
    end else if (read_start) begin
      rd_act <= 1'b1;
      rd_sh <= rd_word;
    end else if (fall && rd_act) begin
      // ones follow the data, so the line returns to idle at a fall and never while the clock is high
      lnk.mgmt_in <= rd_sh[15];
      rd_sh <= {rd_sh[14:0], 1'b1};
      rd_act <= in_frame;
    end
  end

  // latched-high flags: an event in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_flag <= 1'b0;
      del_flag <= 1'b0;
    end else if (rd_stat || soft_reset) begin
      ins_flag <= idle_ins_evt; // R17
      del_flag <= idle_del_evt; // R17
    end else begin
      ins_flag <= ins_flag | idle_ins_evt; // R1
      del_flag <= del_flag | idle_del_evt; // R2
    end
  end

  // control two register, stored values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_loopback <= CTL2_LINE_LB_RST; // R3
      spd_lsb <= CTL2_SPEED_LSB_RST; // R5
      spd_msb <= CTL2_SPEED_MSB_RST; // R5
      rx_tim <= CTL2_RX_TIMING_RST; // R9
      tx_tim <= CTL2_TX_TIMING_RST; // R10
      block_carrier_ext <= CTL2_BLOCK_CEXT_RST; // R11
      rsv2_0 <= CTL2_RSV_2_0_RST;
    end else if (wr_ctl2) begin
      line_loopback <= wdata[CTL2_LINE_LB_BIT]; // R3
      spd_lsb <= wdata[CTL2_SPEED_LSB_BIT];
      spd_msb <= wdata[CTL2_SPEED_MSB_BIT];
      rx_tim <= wdata[CTL2_RX_TIMING_BIT];
      tx_tim <= wdata[CTL2_TX_TIMING_BIT];
      block_carrier_ext <= wdata[CTL2_BLOCK_CEXT_BIT]; // R11
      rsv2_0 <= wdata[2:0];
    end else if (soft_reset) begin
      // speed, timing and carrier bits are retained across soft reset
      line_loopback <= CTL2_LINE_LB_RST; // R3
      rsv2_0 <= CTL2_RSV_2_0_RST;
    end
  end

  // disruptive bits are staged and only reach the link logic at soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_app <= {CTL2_SPEED_MSB_RST, CTL2_SPEED_LSB_RST};
      rx_app <= CTL2_RX_TIMING_RST;
      tx_app <= CTL2_TX_TIMING_RST;
    end else if (soft_reset) begin
      spd_app <= {spd_msb, spd_lsb}; // R8
      rx_app <= rx_tim; // R8
      tx_app <= tx_tim; // R8
    end
  end

  // outputs toward the link logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_clk_1000 <= 1'b0;
      rx_clk_centred <= CTL2_RX_TIMING_RST;
      tx_clk_delayed <= CTL2_TX_TIMING_RST;
    end else begin
      // code 11 is undefined; it is treated as 1000 like the other non-zero codes
      mac_clk_1000 <= speed_override ? (|spd_app) : link_speed_1000; // R4 R6
      rx_clk_centred <= rx_app; // R9
      tx_clk_delayed <= tx_app; // R10
    end
  end

  // impedance override register; the strap is taken once the synchroniser has settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      impedance_cal_go <= 1'b0;
      io_supply_level <= IMP_IO_LEVEL_RST; // R13
      rsv11_8 <= IMP_RSV_11_8_RST;
      rsv7_6 <= IMP_RSV_7_6_RST;
      rsv3_0 <= IMP_RSV_3_0_RST;
      strap_wait <= 2'h0;
    end else begin
      impedance_cal_go <= wr_imp & wdata[IMP_SELF_CLEAR_BIT];
      if (strap_wait != 2'h3)
        strap_wait <= strap_wait + 2'h1;
      if (wr_imp) begin
        io_supply_level <= wdata[IMP_IO_LEVEL_BIT]; // R12
        rsv11_8 <= wdata[11:8]; // R15
        rsv7_6 <= wdata[7:6]; // R16
        rsv3_0 <= wdata[3:0]; // R15
      end else if (strap_wait == 2'h2) begin
        io_supply_level <= strap_s[1] ^ strap_s[0]; // R13
      end
    end
  end
endmodule

// ===== inc/mscs_pkg.sv
package mscs_pkg;
  // management frame: start(0), op(1=read), 5 address bits, 16 data bits, msb first
  localparam int FRAME_BITS = 23;
  localparam logic [4:0] FRAME_ADDR_LAST = 5'h06;
  localparam logic [4:0] FRAME_LAST = 5'h16;
  localparam logic [4:0] FRAME_DATA_FIRST = 5'h07;
  // device register indices
  localparam logic [4:0] REG_MAC_FIFO_STATUS = 5'h13;
  localparam logic [4:0] REG_MAC_IF_CONTROL_TWO = 5'h15;
  localparam logic [4:0] REG_OUTPUT_IMPEDANCE_OVERRIDE = 5'h18;
  // mac_fifo_status fields
  localparam int STAT_IDLE_INS_BIT = 3;
  localparam int STAT_IDLE_DEL_BIT = 2;
  // mac_interface_control_two fields and resets
  localparam int CTL2_LINE_LB_BIT = 14;
  localparam int CTL2_SPEED_LSB_BIT = 13;
  localparam int CTL2_SPEED_MSB_BIT = 6;
  localparam int CTL2_RX_TIMING_BIT = 5;
  localparam int CTL2_TX_TIMING_BIT = 4;
  localparam int CTL2_BLOCK_CEXT_BIT = 3;
  localparam logic CTL2_LINE_LB_RST = 1'h0;
  localparam logic CTL2_SPEED_LSB_RST = 1'h0;
  localparam logic CTL2_SPEED_MSB_RST = 1'h1;
  localparam logic CTL2_RX_TIMING_RST = 1'h1;
  localparam logic CTL2_TX_TIMING_RST = 1'h1;
  localparam logic CTL2_BLOCK_CEXT_RST = 1'h0;
  localparam logic [5:0] CTL2_RSV_12_7 = 6'h20;
  localparam logic [2:0] CTL2_RSV_2_0_RST = 3'h6;
  // output_impedance_override fields
  localparam int IMP_SELF_CLEAR_BIT = 15;
  localparam int IMP_IO_LEVEL_BIT = 13;
  localparam int IMP_IO_18V_BIT = 12;
  localparam logic IMP_IO_LEVEL_RST = 1'h0;
  localparam logic [1:0] IMP_RSV_7_6_RST = 2'h0;
  // controller apb map
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam logic [7:0] APB_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] APB_IRQ_MASK = 8'h10;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_READ_BIT = 24;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  // link clock made by the controller
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ===== inc/mscs_if.sv
`timescale 1ns/10ps
interface mscs_if;
  logic mgmt_clk;
  logic mgmt_out;
  logic mgmt_in;
  modport ctl (output mgmt_clk, output mgmt_out, input mgmt_in);
  modport dev (input mgmt_clk, input mgmt_out, output mgmt_in);
endinterface

// ===== logic/mscs_sync.sv
`timescale 1ns/10ps
module mscs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== logic/mscs_mgmt_ctl.sv
`timescale 1ns/10ps
module mscs_mgmt_ctl
  import mscs_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // management link
  mscs_if.ctl lnk
);
  logic busy, is_rd;
  logic [7:0] div_cnt;
  logic [4:0] bit_cnt;
  logic [22:0] tx_sh;
  logic [15:0] rd_sh, rdata;
  logic [31:0] cmd;
  logic [1:0] irq_stat, irq_mask;
  logic in_s;

  mscs_sync #(.W(1)) u_sin (.clk(pclk), .rst_n(presetn), .d(lnk.mgmt_in), .q(in_s));

  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_cmd = paddr == APB_CMD;
  wire hit_stat = paddr == APB_STATUS;
  wire hit_rdata = paddr == APB_RDATA;
  wire hit_istat = paddr == APB_IRQ_STATUS;
  wire hit_imask = paddr == APB_IRQ_MASK;
  wire mapped = hit_cmd | hit_stat | hit_rdata | hit_istat | hit_imask;
  wire start = wr & hit_cmd & ~busy;
  wire refused = wr & hit_cmd & busy;
  wire tick = busy & (div_cnt == 8'(HALF_CYC - 1));
  wire last_fall = tick & lnk.mgmt_clk & (bit_cnt == FRAME_LAST);

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = hit_cmd ? cmd :
                  hit_stat ? {31'h0, busy} :
                  hit_rdata ? {16'h0000, rdata} :
                  hit_istat ? {30'h0, irq_stat} :
                  hit_imask ? {30'h0, irq_mask} : 32'h0;
  assign irq = |(irq_stat & irq_mask);

  // frame engine: data changes while the link clock is low, the device samples on its rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      is_rd <= 1'b0;
      div_cnt <= 8'h00;
      bit_cnt <= 5'h00;
      tx_sh <= '0;
      rd_sh <= 16'h0000;
      rdata <= 16'h0000;
      cmd <= 32'h0;
      lnk.mgmt_clk <= 1'b0;
      lnk.mgmt_out <= 1'b1;
    end else if (start) begin
      busy <= 1'b1;
      cmd <= pwdata;
      is_rd <= pwdata[CMD_READ_BIT];
      tx_sh <= {1'b0, pwdata[CMD_READ_BIT], pwdata[CMD_ADDR_LSB +: 5], pwdata[15:0]};
      div_cnt <= 8'h00;
      bit_cnt <= 5'h00;
      lnk.mgmt_out <= 1'b0;
    end else if (busy) begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      if (tick && !lnk.mgmt_clk) begin
        lnk.mgmt_clk <= 1'b1;
        if (is_rd && bit_cnt >= FRAME_DATA_FIRST)
          rd_sh <= {rd_sh[14:0], in_s};
      end else if (tick) begin
        lnk.mgmt_clk <= 1'b0;
        if (bit_cnt == FRAME_LAST) begin
          busy <= 1'b0;
          lnk.mgmt_out <= 1'b1;
          if (is_rd)
            rdata <= rd_sh;
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
          lnk.mgmt_out <= tx_sh[21];
          tx_sh <= {tx_sh[21:0], 1'b0};
        end
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      irq_stat[IRQ_DONE_BIT] <= last_fall |
        (irq_stat[IRQ_DONE_BIT] & ~(wr & hit_istat & pwdata[IRQ_DONE_BIT]));
      irq_stat[IRQ_REFUSED_BIT] <= refused |
        (irq_stat[IRQ_REFUSED_BIT] & ~(wr & hit_istat & pwdata[IRQ_REFUSED_BIT]));
      if (wr && hit_imask)
        irq_mask <= pwdata[1:0];
    end
  end
endmodule

// ===== verification/mscs_link_asserts.sv
`timescale 1ns/10ps
module mscs_link_asserts
  import mscs_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic mgmt_clk,
  input wire logic mgmt_out,
  input wire logic mgmt_in
);
  logic clk_q;
  logic out_q;
  logic in_frame;
  logic [4:0] rise_cnt;
  logic [7:0] run_cnt;
  wire rise = mgmt_clk & ~clk_q;
  wire fall = ~mgmt_clk & clk_q;
  wire start = ~in_frame & out_q & ~mgmt_out;
  wire last_fall = fall & (rise_cnt == FRAME_LAST + 5'h01);
  wire [7:0] half_m1 = 8'(HALF_CYC - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      out_q <= 1'b1;
    end else begin
      clk_q <= mgmt_clk;
      out_q <= mgmt_out;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame <= 1'b0;
      rise_cnt <= 5'h00;
    end else if (start) begin
      in_frame <= 1'b1;
      rise_cnt <= 5'h00;
    end else begin
      in_frame <= in_frame & ~last_fall;
      rise_cnt <= rise_cnt + 5'(rise & in_frame);
    end
  end
  // saturates so a long idle low phase cannot wrap into a legal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= 8'hff;
    end else if (mgmt_clk != clk_q || start) begin
      run_cnt <= 8'h00;
    end else if (run_cnt != 8'hff) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  clk_high_a: assert property (fall |-> run_cnt == half_m1) else $error("link clock high phase wrong");
  clk_low_a: assert property (rise && rise_cnt != 5'h00 |-> run_cnt == half_m1) else $error("link clock low phase wrong");
  // the start edge restarts the run counter, so the first rise must come one half period later
  start_bit_a: assert property (rise && in_frame && rise_cnt == 5'h00 |-> run_cnt == half_m1)
    else $error("start bit timing wrong");
  idle_clk_a: assert property (!in_frame |-> !mgmt_clk) else $error("link clock runs outside frame");
  out_change_a: assert property ($changed(mgmt_out) |-> !mgmt_clk) else $error("data changed with clock high");
  in_hold_a: assert property (mgmt_clk && clk_q |-> $stable(mgmt_in)) else $error("read data changed with clock high");
  in_idle_a: assert property (in_frame && rise_cnt >= 5'h01 && rise_cnt < 5'h07 |-> mgmt_in)
    else $error("read line not released before data");
  rise_bound_a: assert property (rise |-> rise_cnt <= FRAME_LAST) else $error("too many link clock rises");
  frame_end_a: assert property (last_fall |-> mgmt_out) else $error("line not idle after frame");
  cover property (start);
  cover property (last_fall);
  cover property (in_frame && !mgmt_in);
endmodule

// ===== verification/mac_side_config_status_regs_tb_top.sv
`timescale 1ns/10ps
module mac_side_config_status_regs_tb_top;
  import mscs_pkg::*;
  // the device needs about five clocks to hand a read bit back through both synchronisers
  localparam int HC = LINK_HALF_CYC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic ins, del, sw_rst, link_up, lsp, mlb, pin18, e;
  logic [1:0] strap, spd_app, c;
  logic line_lb, mac1000, rxc, txc, cext, iolvl, calgo, rx_app, tx_app;
  logic [15:0] ctl2_m, q;
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'h209d1cfe;
  int i;
  mscs_if lnk();
  mscs_mgmt_ctl #(.HALF_CYC(HC)) mscs_mgmt_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lnk(lnk.ctl));
  mscs_phy_regs mscs_phy_regs_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .idle_ins_evt(ins),
    .idle_del_evt(del), .soft_reset(sw_rst), .link_up(link_up), .link_speed_1000(lsp), .mac_loopback_on(mlb),
    .strap_cfg(strap), .io_18v_pin(pin18), .line_loopback(line_lb), .mac_clk_1000(mac1000),
    .rx_clk_centred(rxc), .tx_clk_delayed(txc), .block_carrier_ext(cext), .io_supply_level(iolvl),
    .impedance_cal_go(calgo));
  mscs_link_asserts #(.HALF_CYC(HC)) mscs_link_asserts_inst (.pclk(pclk), .presetn(presetn),
    .mgmt_clk(lnk.mgmt_clk), .mgmt_out(lnk.mgmt_out), .mgmt_in(lnk.mgmt_in));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task give_verdict;
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    int k;
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the answer is read while it stands before the edge, so the design's update at that edge cannot race it
    for (k = 0; k < 20; k++) begin
      @(negedge pclk);
      rdy = pready;
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      if (rdy === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_idle;
    logic [31:0] s;
    logic er;
    int k;
    for (k = 0; k < 500; k++) begin
      apb(1'b0, APB_STATUS, 32'h0, s, er);
      if (s[0] === 1'b0) break;
    end
    if (k == 500) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task frame(input logic rd, input logic [4:0] a, input logic [15:0] d, output logic [15:0] dq);
    logic [31:0] s;
    logic er;
    apb(1'b1, APB_CMD, {7'h00, rd, 3'h0, a, d}, s, er);
    wait_idle();
    apb(1'b0, APB_RDATA, 32'h0, s, er);
    dq = s[15:0];
  endtask
  task stat(input logic [1:0] ev, input logic [15:0] exp);
    @(posedge pclk);
    ins <= ev[1];
    del <= ev[0];
    @(posedge pclk);
    ins <= 1'b0;
    del <= 1'b0;
    frame(1'b1, REG_MAC_FIFO_STATUS, 16'h0, q);
    chk_word(q, exp);
  endtask
  // link down or mac loopback: staged code picks speed, any nonzero code is 1000
  function automatic logic exp_mac();
    return (link_up && !mlb) ? lsp : (spd_app != 2'b00);
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, ins, del, sw_rst, link_up, lsp, mlb} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 2'b10;
    pin18 = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    ctl2_m = 16'h1076;
    spd_app = 2'b10;
    rx_app = 1'b1;
    tx_app = 1'b1;
    chk_pin(mac1000, exp_mac());
    chk_pin(rxc, 1'b1);
    chk_pin(txc, 1'b1);
    chk_pin(cext | line_lb, 1'b0);
    chk_pin(iolvl, 1'b1);
    frame(1'b1, REG_MAC_IF_CONTROL_TWO, 16'h0, q);
    chk_word(q, ctl2_m);
    stat(2'b00, 16'h0000);
    stat(2'b10, 16'h0008);
    stat(2'b00, 16'h0000);
    stat(2'b01, 16'h0004);
    stat(2'b11, 16'h000c);
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      c = 2'(i % 3);
      ctl2_m = (r[15:0] & 16'h4038) | 16'h1006 | (16'(c[0]) << 13) | (16'(c[1]) << 6);
      frame(1'b0, REG_MAC_IF_CONTROL_TWO, ctl2_m, q);
      chk_pin(line_lb, ctl2_m[14]);
      chk_pin(cext, ctl2_m[3]);
      chk_pin(mac1000, exp_mac());
      chk_pin(rxc, rx_app);
      spd_app = {ctl2_m[6], ctl2_m[13]};
      rx_app = ctl2_m[5];
      tx_app = ctl2_m[4];
      ctl2_m[14] = 1'b0;
      link_up <= r[16];
      mlb <= r[17];
      lsp <= r[17] ? (c != 2'b00) : r[18];
      @(posedge pclk);
      sw_rst <= 1'b1;
      @(posedge pclk);
      sw_rst <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_pin(mac1000, exp_mac());
      chk_pin(rxc, rx_app);
      chk_pin(txc, tx_app);
      chk_pin(line_lb, 1'b0);
      frame(1'b1, REG_MAC_IF_CONTROL_TWO, 16'h0, q);
      chk_word(q, ctl2_m);
    end
    frame(1'b1, REG_OUTPUT_IMPEDANCE_OVERRIDE, 16'h0, q);
    chk_word(q, 16'h3000);
    frame(1'b0, REG_OUTPUT_IMPEDANCE_OVERRIDE, q & 16'hdfff, q);
    chk_pin(iolvl, 1'b0);
    chk_pin(calgo, 1'b0);
    pin18 <= 1'b0;
    frame(1'b1, REG_OUTPUT_IMPEDANCE_OVERRIDE, 16'h0, q);
    chk_word(q, 16'h0000);
    frame(1'b1, 5'h02, 16'h0, q);
    chk_word(q, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk_word({r[30:0], e}, 32'h1);
    apb(1'b0, APB_IRQ_STATUS, 32'h0, r, e);
    chk_word(r, 32'h1);
    chk_pin(irq, 1'b0);
    apb(1'b1, APB_IRQ_MASK, 32'h3, r, e);
    @(posedge pclk);
    chk_pin(irq, 1'b1);
    apb(1'b1, APB_IRQ_STATUS, 32'h1, r, e);
    @(posedge pclk);
    chk_pin(irq, 1'b0);
    // second command lands while the first frame is still on the wire
    apb(1'b1, APB_CMD, 32'h01130000, r, e);
    apb(1'b1, APB_CMD, 32'h01150000, r, e);
    apb(1'b0, APB_IRQ_STATUS, 32'h0, r, e);
    chk_word(r, 32'h2);
    wait_idle();
    apb(1'b0, APB_IRQ_STATUS, 32'h0, r, e);
    chk_word(r, 32'h3);
    apb(1'b1, APB_IRQ_STATUS, 32'h3, r, e);
    @(posedge pclk);
    chk_pin(irq, 1'b0);
    give_verdict();
  end
endmodule
